// [logic/smfc_top.sv]
// Mode decode, step sequencing, chopping timing and fault shutdown of a two-phase stepper driver.
// Assumes pin inputs are asynchronous to pclk and an APB master reaches the registers.
//
// Notes on behaviour
// - Direction high: winding A leads B by quarter.
// - Charge start polarity follows the direction input.
// - All select bits low: standby, chopper stopped, outputs off.
// - Select code picks full to thirty-second resolution.
// - Overtemperature latches outputs off until supply or standby.
// - Thermal dead band is 15 to 16 oscillator periods.
// - Overcurrent latches outputs off until supply or standby.
// - Overcurrent dead band is 7 to 8 oscillator periods.
// - Two open-drain monitor outputs, host pulls them up.
// - Step rising edge advances angle, falling edge ignored.
// - Output enable low puts outputs in high impedance.
// - One chopping cycle is sixteen oscillator clocks.
`timescale 1ns/1ps
`default_nettype none

module smfc_top
    import smfc_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input  wire logic              pclk,                   // 40 MHz clock
    input  wire logic              presetn,                // Async reset, active low
    input  wire logic              clk_en,                 // Freezes all state when low
    input  wire logic              psel,                   // APB select
    input  wire logic              penable,                // APB access phase
    input  wire logic              pwrite,                 // APB direction
    input  wire logic [ADDR_W-1:0] paddr,                  // APB byte address
    input  wire logic [31:0]       pwdata,                 // APB write data
    output logic      [31:0]       prdata,                 // APB read data
    output logic                   pready,                 // APB ready
    output logic                   pslverr,                // APB error, unmapped address
    input  wire logic              step_clock,             // Step pin
    input  wire logic              rotation_direction,     // Direction pin
    input  wire logic              resolution_select_bit2, // Select, most significant
    input  wire logic              resolution_select_bit1, // Select, middle
    input  wire logic              resolution_select_bit0, // Select, least significant
    input  wire logic              angle_reset_n,          // Angle reset pin, active low
    input  wire logic              output_enable,          // Output stage enable pin
    input  wire logic              overtemp_detect,        // Thermal sensor comparator
    input  wire logic              overcurrent_detect,     // Current sensor comparator
    input  wire logic              motor_supply_ok,        // Motor supply present
    output logic                   winding_a_pos,          // Winding A positive leg high
    output logic                   winding_a_neg,          // Winding A negative leg high
    output logic                   winding_a_drive_en,     // Winding A bridge driven
    output logic                   winding_b_pos,          // Winding B positive leg high
    output logic                   winding_b_neg,          // Winding B negative leg high
    output logic                   winding_b_drive_en,     // Winding B bridge driven
    output logic                   monitor_output_one_o,   // Open-drain level, always low
    output logic                   monitor_output_one_oe,  // Pulls low at initial angle
    output logic                   monitor_output_two_o,   // Open-drain level, always low
    output logic                   monitor_output_two_oe,  // Pulls low on latched fault
    output logic                   irq                     // Level interrupt
);

    // Pin synchroniser: three stages, a change counts when stages two and three agree
    smfc_pins_s pin_raw;
    logic [PIN_W-1:0] sync1, sync2, sync3;
    smfc_pins_s flt;
    logic [PIN_W-1:0] next_flt;

    // Fields in smfc_pins_s order
    assign pin_raw = {step_clock, rotation_direction, resolution_select_bit2,
                      resolution_select_bit1, resolution_select_bit0, angle_reset_n,
                      output_enable, overtemp_detect, overcurrent_detect, motor_supply_ok};

    always_comb begin
        next_flt = (sync3 & ~(sync2 ^ sync3)) | (flt & (sync2 ^ sync3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sync1, sync2, sync3, flt} <= '0;
        end else if (clk_en) begin
            {sync3, sync2, sync1} <= {sync2, sync1, pin_raw};
            flt   <= next_flt;
        end
    end

    // Core state
    smfc_mode_e              mode, next_mode;
    logic [ACC_W-1:0]        osc_acc, next_osc_acc;
    logic                    osc_tick;
    logic [DEAD_W-1:0]       tsd_cnt, next_tsd_cnt, isd_cnt, next_isd_cnt;
    logic                    tsd_lat, next_tsd_lat, isd_lat, next_isd_lat;
    logic [31:0]             settle_cnt, next_settle_cnt;
    logic [CHOP_DIV_W-1:0]   div_cnt, next_div_cnt;
    logic [CHOP_PH_W-1:0]    chop_ph, next_chop_ph;
    logic [ANGLE_W-1:0]      angle, next_angle;
    logic                    step_prev;
    logic [CHOP_PH_W-1:0]    charge_len;
    logic [CHOP_DIV_W-1:0]   chop_div;
    logic [ST_W-1:0]         status, next_status, mask;
    logic [ST_W-1:0]         events, rd_clear;
    logic                    standby, step_rise, active, charge;
    logic [ANGLE_W-1:0]      step_size, phase_b;
    logic                    pol_a, pol_b;
    logic                    next_a_pos, next_a_neg, next_b_pos, next_b_neg, next_drive;

    assign standby   = (flt.res_sel == RES_STANDBY);
    assign step_rise = flt.step_clock & ~step_prev;

    always_comb begin
        case (smfc_res_e'(flt.res_sel))
            RES_FULL:    step_size = STEP_FULL;
            RES_HALF_A:  step_size = STEP_HALF;
            RES_QUARTER: step_size = STEP_QUARTER;
            RES_HALF_B:  step_size = STEP_HALF;
            RES_EIGHTH:  step_size = STEP_EIGHTH;
            RES_SIXTEEN: step_size = STEP_SIXTEENTH;
            RES_THIRTY2: step_size = STEP_THIRTYSECOND;
            default:     step_size = ANGLE_INIT;
        endcase
    end

    always_comb begin
        // Fixed oscillator as a fractional divider: 6.4 ticks per 40 pclk cycles
        next_osc_acc = osc_acc + ACC_STEP;
        osc_tick     = 1'b0;
        if (next_osc_acc >= ACC_WRAP) begin
            next_osc_acc = next_osc_acc - ACC_WRAP;
            osc_tick     = 1'b1;
        end

        // Dead bands restart whenever the detector drops, so spikes never trip
        next_tsd_cnt = tsd_cnt;
        if (!flt.overtemp)
            next_tsd_cnt = '0;
        else if (osc_tick && tsd_cnt != TSD_DEAD_TICKS)
            next_tsd_cnt = tsd_cnt + 1'b1;
        next_isd_cnt = isd_cnt;
        if (!flt.overcurrent)
            next_isd_cnt = '0;
        else if (osc_tick && isd_cnt != ISD_DEAD_TICKS)
            next_isd_cnt = isd_cnt + 1'b1;

        // Latches release only on supply loss or standby
        next_tsd_lat = tsd_lat | (tsd_cnt == TSD_DEAD_TICKS);
        next_isd_lat = isd_lat | (isd_cnt == ISD_DEAD_TICKS);
        if (!flt.motor_supply_ok || standby) begin
            next_tsd_lat = 1'b0;
            next_isd_lat = 1'b0;
        end

        next_mode       = mode;
        next_settle_cnt = settle_cnt;
        case (mode)
            MODE_STANDBY: begin
                next_settle_cnt = '0;
                if (!standby)
                    next_mode = MODE_SETTLE;
            end
            MODE_SETTLE: begin
                next_settle_cnt = settle_cnt + 1;
                if (settle_cnt == 32'(SETTLE_COUNT - 1))
                    next_mode = MODE_RUN;
            end
            MODE_RUN: begin
                if (tsd_lat || isd_lat)
                    next_mode = MODE_FAULT;
            end
            MODE_FAULT: begin
                if (!tsd_lat && !isd_lat)
                    next_mode = MODE_RUN;
            end
            default: next_mode = MODE_STANDBY;
        endcase
        if (standby)
            next_mode = MODE_STANDBY;

        // Chopping oscillator stops in standby
        next_div_cnt = div_cnt;
        next_chop_ph = chop_ph;
        if (standby) begin
            next_div_cnt = '0;
            next_chop_ph = '0;
        end else if (div_cnt >= chop_div) begin
            next_div_cnt = '0;
            next_chop_ph = chop_ph + 1'b1;
        end else begin
            next_div_cnt = div_cnt + 1'b1;
        end

        next_angle = angle;
        if (!flt.angle_reset_n)
            next_angle = ANGLE_INIT;
        else if (step_rise && mode == MODE_RUN) begin
            if (flt.rotation_direction)
                next_angle = angle + step_size;
            else
                next_angle = angle - step_size;
        end
    end

    // Bridge drive: B trails A by a quarter period, so stepping down makes B lead
    assign phase_b = angle - ANGLE_QUARTER;
    assign active  = (mode == MODE_RUN) && flt.output_enable;
    assign charge  = (chop_ph < charge_len);
    assign pol_a   = (~angle[ANGLE_W-1]) == flt.rotation_direction;
    assign pol_b   = (~phase_b[ANGLE_W-1]) == flt.rotation_direction;

    always_comb begin
        next_drive = active;
        next_a_pos = active & charge & pol_a;
        next_a_neg = active & charge & ~pol_a;
        next_b_pos = active & charge & pol_b;
        next_b_neg = active & charge & ~pol_b;
    end

    // Events and sticky status; a set in the clearing cycle survives
    assign events = {(mode == MODE_SETTLE) && (next_mode == MODE_RUN),
                     (mode != MODE_STANDBY) && standby,
                     ~isd_lat & next_isd_lat,
                     ~tsd_lat & next_tsd_lat};

    always_comb begin
        next_status = (status & ~rd_clear) | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode  <= MODE_STANDBY;
            angle <= ANGLE_INIT;
            {osc_acc, tsd_cnt, isd_cnt, tsd_lat, isd_lat, settle_cnt} <= '0;
            {div_cnt, chop_ph, step_prev, status} <= '0;
            {winding_a_pos, winding_a_neg, winding_a_drive_en} <= '0;
            {winding_b_pos, winding_b_neg, winding_b_drive_en} <= '0;
            {monitor_output_one_o, monitor_output_one_oe, irq} <= '0;
            {monitor_output_two_o, monitor_output_two_oe} <= '0;
        end else if (clk_en) begin
            mode                  <= next_mode;
            osc_acc               <= next_osc_acc;
            {tsd_cnt, isd_cnt}    <= {next_tsd_cnt, next_isd_cnt};
            {tsd_lat, isd_lat}    <= {next_tsd_lat, next_isd_lat};
            settle_cnt            <= next_settle_cnt;
            {div_cnt, chop_ph}    <= {next_div_cnt, next_chop_ph};
            angle                 <= next_angle;
            step_prev             <= flt.step_clock;
            status                <= next_status;
            {winding_a_pos, winding_a_neg} <= {next_a_pos, next_a_neg};
            {winding_b_pos, winding_b_neg} <= {next_b_pos, next_b_neg};
            {winding_a_drive_en, winding_b_drive_en} <= {2{next_drive}};
            {monitor_output_one_o, monitor_output_two_o} <= 2'b00;
            monitor_output_one_oe <= (angle == ANGLE_INIT);
            monitor_output_two_oe <= tsd_lat | isd_lat;
            irq                   <= |(next_status & mask);
        end
    end

    // APB slave: one wait-free access phase, read data prepared in the setup cycle
    logic        acc_wr, setup, hit;
    logic [31:0] rd_val;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic [CHOP_PH_W-1:0]  next_charge_len;
    logic [CHOP_DIV_W-1:0] next_chop_div;
    logic [ST_W-1:0]       next_mask, next_rd_clear;
    logic [ST_W-1:0]       rd_snap;

    assign setup  = psel & ~penable;
    assign acc_wr = psel & penable & pready & pwrite & ~pslverr;
    // Only bits already shown to software are cleared, so late events are kept
    assign rd_clear = (psel & penable & pready & ~pwrite & (paddr == ADDR_STATUS))
                      ? rd_snap : '0;

    always_comb begin
        hit    = 1'b1;
        rd_val = '0;
        case (paddr)
            ADDR_CTRL:   rd_val[CHOP_PH_W-1:0]  = charge_len;
            ADDR_CHOP:   rd_val[CHOP_DIV_W-1:0] = chop_div;
            ADDR_STATUS: rd_val[ST_W-1:0]       = status;
            ADDR_MASK:   rd_val[ST_W-1:0]       = mask;
            ADDR_STATE: begin
                rd_val[SF_ANGLE +: ANGLE_W] = angle;
                rd_val[SF_RES +: 3]         = flt.res_sel;
                rd_val[SF_MODE +: 2]        = mode;
                rd_val[SF_TSD]              = tsd_lat;
                rd_val[SF_ISD]              = isd_lat;
            end
            default:     hit = 1'b0;
        endcase
        next_pready     = setup;
        next_pslverr    = setup & ~hit;
        next_prdata     = (setup && !pwrite) ? rd_val : prdata;
        next_rd_clear   = setup ? rd_val[ST_W-1:0] : rd_snap;
        next_charge_len = charge_len;
        next_chop_div   = chop_div;
        next_mask       = mask;
        if (acc_wr && paddr == ADDR_CTRL)
            next_charge_len = pwdata[CHOP_PH_W-1:0];
        if (acc_wr && paddr == ADDR_CHOP)
            next_chop_div = pwdata[CHOP_DIV_W-1:0];
        if (acc_wr && paddr == ADDR_MASK)
            next_mask = pwdata[ST_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {prdata, pready, pslverr, rd_snap} <= '0;
            charge_len <= CHARGE_RST;
            chop_div   <= CHOP_DIV_RST;
            mask       <= MASK_RST;
        end else if (clk_en) begin
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            rd_snap    <= next_rd_clear;
            charge_len <= next_charge_len;
            chop_div   <= next_chop_div;
            mask       <= next_mask;
        end
    end

endmodule : smfc_top

`default_nettype wire

// [logic/smfc_pkg.sv]
// Shared constants, types and the register map of the stepper mode and fault control block.
// Assumes a single 40 MHz clock domain; every number used by the logic is named here.
package smfc_pkg;

    // Clock and fixed oscillator rates
    localparam int CLK_KHZ         = 40000;
    localparam int FIXED_OSC_KHZ   = 6400;
    localparam int ACC_W           = 16;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(FIXED_OSC_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

    // Settling time after standby release, in microseconds, and its cycle count
    localparam int SETTLE_US       = 1000;
    localparam int SETTLE_CYCLES   = (SETTLE_US * CLK_KHZ + 999) / 1000;

    // Dead bands in fixed oscillator ticks; a count of N spans N-1 to N periods
    localparam int DEAD_W          = 5;
    localparam logic [DEAD_W-1:0] TSD_DEAD_TICKS = 5'h10;
    localparam logic [DEAD_W-1:0] ISD_DEAD_TICKS = 5'h08;

    // Chopping: one cycle is sixteen chopping oscillator clocks
    localparam int CHOP_PH_W       = 4;
    localparam int CHOP_DIV_W      = 16;

    // Electrical angle: 128 units per electrical period, a quarter period is 32
    localparam int ANGLE_W         = 7;
    localparam logic [ANGLE_W-1:0] ANGLE_QUARTER = 7'h20;
    localparam logic [ANGLE_W-1:0] ANGLE_INIT    = 7'h00;
    localparam logic [ANGLE_W-1:0] STEP_FULL     = 7'h20;
    localparam logic [ANGLE_W-1:0] STEP_HALF     = 7'h10;
    localparam logic [ANGLE_W-1:0] STEP_QUARTER  = 7'h08;
    localparam logic [ANGLE_W-1:0] STEP_EIGHTH   = 7'h04;
    localparam logic [ANGLE_W-1:0] STEP_SIXTEENTH = 7'h02;
    localparam logic [ANGLE_W-1:0] STEP_THIRTYSECOND = 7'h01;

    typedef enum logic [2:0] {
        RES_STANDBY = 3'b000,
        RES_FULL    = 3'b001,
        RES_HALF_A  = 3'b010,
        RES_QUARTER = 3'b011,
        RES_HALF_B  = 3'b100,
        RES_EIGHTH  = 3'b101,
        RES_SIXTEEN = 3'b110,
        RES_THIRTY2 = 3'b111
    } smfc_res_e;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_SETTLE  = 2'b01,
        MODE_RUN     = 2'b10,
        MODE_FAULT   = 2'b11
    } smfc_mode_e;

    // Pin inputs, carried together through the synchroniser
    typedef struct packed {
        logic       step_clock;
        logic       rotation_direction;
        logic [2:0] res_sel;
        logic       angle_reset_n;
        logic       output_enable;
        logic       overtemp;
        logic       overcurrent;
        logic       motor_supply_ok;
    } smfc_pins_s;
    localparam int PIN_W = $bits(smfc_pins_s);

    // APB register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_CHOP   = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_STATE  = 12'h010;

    // Reset values: CTRL charge length in chopping clocks, low four bits; CHOP chopping clock divider
    localparam logic [CHOP_PH_W-1:0]  CHARGE_RST   = 4'h8;
    localparam logic [CHOP_DIV_W-1:0] CHOP_DIV_RST = 16'h0024;

    // STATUS and MASK bit positions
    localparam int ST_TSD   = 0;
    localparam int ST_ISD   = 1;
    localparam int ST_STBY  = 2;
    localparam int ST_READY = 3;
    localparam int ST_W     = 4;
    localparam logic [ST_W-1:0] MASK_RST = 4'h0;

    // STATE fields
    localparam int SF_ANGLE = 0;
    localparam int SF_RES   = 8;
    localparam int SF_MODE  = 12;
    localparam int SF_TSD   = 16;
    localparam int SF_ISD   = 17;

endpackage : smfc_pkg

// [sim/smfc_chk.sv]
// Port-level assertions for smfc_top, attached by bind.
// Assumes slow pin changes and faults raised only while running.
`timescale 1ns/1ps
`default_nettype none
module smfc_chk (
    input wire logic pclk,                   // Clock
    input wire logic presetn,                // Reset, active low
    input wire logic pready,                 // APB ready
    input wire logic pslverr,                // APB error
    input wire logic resolution_select_bit2, // Select MSB
    input wire logic resolution_select_bit1, // Select mid
    input wire logic resolution_select_bit0, // Select LSB
    input wire logic output_enable,          // Stage enable
    input wire logic overtemp_detect,        // Thermal detector
    input wire logic overcurrent_detect,     // Current detector
    input wire logic motor_supply_ok,        // Supply present
    input wire logic winding_a_pos,          // A positive leg
    input wire logic winding_a_neg,          // A negative leg
    input wire logic winding_a_drive_en,     // A driven
    input wire logic winding_b_drive_en,     // B driven
    input wire logic monitor_output_one_o,   // Monitor one level
    input wire logic monitor_output_two_o,   // Monitor two level
    input wire logic monitor_output_two_oe   // Fault latch pulls low
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire stby = !resolution_select_bit2 && !resolution_select_bit1 && !resolution_select_bit0;
    wire off  = !winding_a_drive_en && !winding_b_drive_en;

    AST_OD_LOW: assert property (!monitor_output_one_o && !monitor_output_two_o)
        else $error("open-drain level driven high");
    AST_LEG_EXCL: assert property (!(winding_a_pos && winding_a_neg))
        else $error("both legs of winding a high");
    AST_HIZ: assert property (!output_enable [*8] |-> off)
        else $error("bridge driven while disabled");
    AST_STBY_OFF: assert property (stby [*8] |-> off)
        else $error("bridge driven in standby");
    AST_ISD_DEAD: assert property ($rose(monitor_output_two_oe) |->
        $past(overcurrent_detect, 40) || $past(overtemp_detect, 40))
        else $error("fault latched before dead band");
    AST_TSD_DEAD: assert property ($rose(monitor_output_two_oe)
        && !$past(overcurrent_detect, 40) |-> $past(overtemp_detect, 90))
        else $error("thermal latch before dead band");
    AST_ISD_BOUND: assert property ($rose(overcurrent_detect) && motor_supply_ok |->
        ##[1:70] (monitor_output_two_oe || !overcurrent_detect))
        else $error("overcurrent latch late");
    AST_TSD_BOUND: assert property ($rose(overtemp_detect) && motor_supply_ok |->
        ##[1:130] (monitor_output_two_oe || !overtemp_detect))
        else $error("thermal latch late");
    AST_FAULT_OFF: assert property (monitor_output_two_oe [*3] |-> off)
        else $error("bridge driven during fault");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error without ready");

    cover property ($rose(monitor_output_two_oe));
    cover property (pslverr);
    cover property ($rose(winding_a_pos));
endmodule : smfc_chk

bind smfc_top smfc_chk chk (.*);
`default_nettype wire

// [sim/smfc_host.sv]
// Host controller model driving step, direction and select pins.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module smfc_host #(
    parameter int WAIT_CYCLES = 40
) (
    input  wire logic pclk,                   // Clock
    output logic      step_clock,             // Step pin
    output logic      rotation_direction,     // Direction pin
    output logic      resolution_select_bit2, // Select MSB
    output logic      resolution_select_bit1, // Select mid
    output logic      resolution_select_bit0, // Select LSB
    output logic      angle_reset_n           // Angle reset, active low
);
    initial begin
        {step_clock, rotation_direction, angle_reset_n} = 3'b001;
        {resolution_select_bit2, resolution_select_bit1, resolution_select_bit0} = 3'b000;
    end
    // Angle reset is held across the select change so no half-applied code steps
    task automatic set_res(input logic [2:0] code);
        @(posedge pclk) angle_reset_n <= 1'b0;
        @(posedge pclk) {resolution_select_bit2, resolution_select_bit1,
            resolution_select_bit0} <= code;
        repeat (8) @(posedge pclk);
        angle_reset_n <= 1'b1;
        repeat (WAIT_CYCLES) @(posedge pclk);
    endtask : set_res
    task automatic steps(input int n, input logic dir);
        @(posedge pclk) rotation_direction <= dir;
        for (int i = 0; i < n; i++) begin
            repeat (6) @(posedge pclk);
            step_clock <= 1'b1;
            repeat (6) @(posedge pclk);
            step_clock <= 1'b0;
        end
        repeat (8) @(posedge pclk);
    endtask : steps
endmodule : smfc_host
`default_nettype wire

// [sim/smfc_top_test.sv]
// Self-checking bench for smfc_top: registers, modes, stepping and fault shutdown.
// Assumes smfc_host drives the step and select pins and smfc_chk is bound.
`timescale 1ns/1ps
`default_nettype none
module smfc_top_test;
    import smfc_pkg::*;
    logic              pclk = 1'b0, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, q;
    logic              step_clock, rotation_direction, angle_reset_n, output_enable, irq;
    logic              resolution_select_bit2, resolution_select_bit1, resolution_select_bit0;
    logic              overtemp_detect, overcurrent_detect, motor_supply_ok;
    logic              winding_a_pos, winding_a_neg, winding_a_drive_en;
    logic              winding_b_pos, winding_b_neg, winding_b_drive_en;
    logic              monitor_output_one_o, monitor_output_one_oe;
    logic              monitor_output_two_o, monitor_output_two_oe;
    logic [3:0]        seen;
    integer            fails = 0, num_checks = 0, n, seed;
    // External pull-ups on both monitors
    wire mon_one = monitor_output_one_oe ? monitor_output_one_o : 1'b1;
    wire mon_two = monitor_output_two_oe ? monitor_output_two_o : 1'b1;
    wire [1:0] drv = {winding_a_drive_en, winding_b_drive_en};
    smfc_top #(.SETTLE_COUNT(20)) uut (.*);
    smfc_host #(.WAIT_CYCLES(40)) host (.*);
    always #12.5 pclk = ~pclk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int w = 0;
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk) w++; while (pready !== 1'b1 && w < 20);
        q = prdata;
        chk(32'(pready), 32'h1, "no ready");
        chk(32'(pslverr), 32'(a > ADDR_STATE), "slave error");
        {psel, penable} <= 2'b00;
    endtask : apb
    function automatic logic [6:0] step_of(input logic [2:0] c);
        case (c)
            3'b001: return STEP_FULL;
            3'b010, 3'b100: return STEP_HALF;
            3'b011: return STEP_QUARTER;
            3'b101: return STEP_EIGHTH;
            3'b110: return STEP_SIXTEENTH;
            default: return STEP_THIRTYSECOND;
        endcase
    endfunction : step_of

    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h51538964;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        {output_enable, overtemp_detect, overcurrent_detect, motor_supply_ok} = 4'b1001;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'(CHARGE_RST), "ctrl reset");
        apb(1'b0, ADDR_CHOP, 32'h0);
        chk(q, 32'(CHOP_DIV_RST), "chop reset");
        apb(1'b0, ADDR_MASK, 32'h0);
        chk(q, 32'(MASK_RST), "mask reset");
        apb(1'b1, 12'h014, 32'hffff_ffff);
        apb(1'b0, 12'h014, 32'h0);
        chk(q, 32'h0, "unmapped read");
        apb(1'b1, ADDR_MASK, 32'h1 << ST_ISD);
        for (int c = 1; c < 8; c++) begin
            n = 1 + $unsigned($random(seed)) % 4;
            host.set_res(3'(c));
            chk(32'(mon_one), 32'h0, "initial angle monitor");
            apb(1'b0, ADDR_STATE, 32'h0);
            chk(32'(q[13:8]), 32'({MODE_RUN, 1'b0, 3'(c)}), "mode and code");
            host.steps(n, 1'b1);
            host.steps(1, 1'b0);
            apb(1'b0, ADDR_STATE, 32'h0);
            chk(32'(q[6:0]), 32'(7'(step_of(3'(c)) * (n - 1))), "angle");
            chk(32'(mon_one), 32'(n != 1), "moved monitor");
        end
        host.set_res(3'b001);
        for (int d = 1; d >= 0; d--) begin
            host.steps(0, d[0]);
            seen = '0;
            repeat (800) @(posedge pclk)
                seen |= {winding_a_pos, winding_a_neg, winding_b_pos, winding_b_neg};
            chk(32'(seen), 32'({d[0], !d[0], !d[0], d[0]}), "charge polarity");
        end
        output_enable <= 1'b0;
        repeat (12) @(posedge pclk);
        chk(32'(drv), 32'h0, "disabled stage");
        output_enable <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        overcurrent_detect <= 1'b1;
        repeat (40) @(posedge pclk);
        chk(32'(mon_two), 32'h1, "overcurrent early");
        repeat (30) @(posedge pclk);
        overcurrent_detect <= 1'b0;
        chk(32'({mon_two, drv, irq}), 32'h1, "overcurrent shutdown");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(q[ST_ISD]), 32'h1, "overcurrent status");
        repeat (3) @(posedge pclk);
        chk(32'({mon_two, irq}), 32'h0, "latched, irq cleared");
        motor_supply_ok <= 1'b0;
        repeat (8) @(posedge pclk);
        motor_supply_ok <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(mon_two), 32'h1, "supply release");
        overtemp_detect <= 1'b1;
        repeat (90) @(posedge pclk);
        chk(32'(mon_two), 32'h1, "thermal early");
        repeat (40) @(posedge pclk);
        chk(32'({mon_two, drv, irq}), 32'h0, "thermal shutdown, masked");
        overtemp_detect <= 1'b0;
        host.set_res(3'b000);
        host.steps(2, 1'b1);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk({q[13:12], q[6:0]}, 32'({MODE_STANDBY, ANGLE_INIT}), "standby ignores steps");
        chk(32'({mon_two, drv}), 32'h4, "standby release");
        tally_and_finish();
    end
endmodule : smfc_top_test
`default_nettype wire
